// ==== src/protected_serial_eeprom_cmd.sv ====
`timescale 1ns/100ps
`default_nettype none
module protected_serial_eeprom_cmd #(
  parameter int WRITE_CYCLES = eep_pkg::WRITE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic chipSelect,
  input  wire logic shiftClock,
  input  wire logic serialIn,
  input  wire logic protectAccessPin,
  input  wire logic programEnablePin,
  output logic      serialOut,
  output logic      serialOutEn,
  output logic      programBusy
);
  eep_pkg::core_state_t st;
  eep_pkg::core_state_t nxt;
  eep_pkg::pins_t       pinRaw;
  eep_pkg::pins_t       pin;
  logic                 shiftRise;
  logic                 csFall;
  logic                 guard;
  logic                 progEn;
  logic                 canWrite;
  logic [9:0]           w;
  logic [7:0]           ea;
  logic                 pushValid;
  logic                 pushReady;
  logic [15:0]          pushData;
  logic                 popValid;
  logic                 popReady;
  logic [15:0]          popData;

  assign pinRaw = '{chipSel: chipSelect, shiftClock: shiftClock, serialIn: serialIn,
                    protectAccess: protectAccessPin, programEnable: programEnablePin};

  pin_sync #(
    .W ($bits(eep_pkg::pins_t))
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .d        (pinRaw),
    .q        (pin)
  );

  // prefetch keeps the shifter fed without stalling on the array
  word_fifo #(
    .W     (eep_pkg::DATA_W),
    .DEPTH (eep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .flush    (!pin.chipSel),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popData)
  );

  assign shiftRise = pin.shiftClock && !st.shiftPrev;
  assign csFall = !pin.chipSel && st.csPrev;
  assign guard = pin.protectAccess;
  assign progEn = pin.programEnable;
  assign w = {st.cmdSr[8:0], pin.serialIn};
  assign ea = w[7:0] & eep_pkg::ADDR_MASK;
  assign canWrite = !st.guardValid || (ea < st.guardAddr);
  assign pushValid = st.prefRun && pin.chipSel;
  assign pushData = st.mem[st.prefAddr[6:0]];

  always_comb begin
    nxt = st;
    popReady = 1'b0;
    nxt.shiftPrev = pin.shiftClock;
    nxt.csPrev = pin.chipSel;
    if (pushValid && pushReady) begin
      nxt.prefAddr = (st.prefAddr + 8'h01) & eep_pkg::ADDR_MASK;
    end
    if (st.busy) begin
      if (st.busyCnt == eep_pkg::BUSY_W'(WRITE_CYCLES - 1)) begin
        nxt.busy = 1'b0;
        nxt.pendOp = eep_pkg::CMD_NONE;
        unique case (st.pendOp)
          eep_pkg::CMD_NONE: begin
          end
          eep_pkg::WRITE_ONE_CMD: begin
            nxt.mem[st.pendAddr[6:0]] = st.pendData;
          end
          eep_pkg::FILL_ALL_CMD: begin
            for (int i = 0; i < eep_pkg::ARRAY_DEPTH; i++) begin
              nxt.mem[i] = st.pendData;
            end
          end
          eep_pkg::GUARD_CLEAR_CMD: begin
            nxt.guardValid = 1'b0;
            nxt.guardAddr = eep_pkg::FIELD_ZERO;
          end
          eep_pkg::GUARD_SET_CMD: begin
            nxt.guardValid = 1'b1;
            nxt.guardAddr = st.pendAddr;
          end
          eep_pkg::GUARD_FREEZE_CMD: begin
            nxt.frozen = 1'b1;
          end
          default: begin
          end
        endcase
      end else begin
        nxt.busyCnt = st.busyCnt + 1'b1;
      end
    end
    if (!pin.chipSel) begin
      nxt.phase = eep_pkg::P_IDLE;
      nxt.doutEn = 1'b0;
      nxt.prefRun = 1'b0;
      nxt.armOp = eep_pkg::CMD_NONE;
      if (csFall && st.phase == eep_pkg::P_DONE && st.armOp != eep_pkg::CMD_NONE &&
          !st.busy) begin
        nxt.busy = 1'b1;
        nxt.busyCnt = '0;
        nxt.pendOp = st.armOp;
        nxt.pendAddr = st.cmdAddr;
        nxt.pendData = st.dataSr;
        nxt.statusShow = 1'b1;
      end
    end else begin
      unique case (st.phase)
        eep_pkg::P_IDLE: begin
          if (st.statusShow) begin
            nxt.dout = !nxt.busy;
            nxt.doutEn = 1'b1;
          end
          // a start bit while busy is refused, status stays up
          if (shiftRise && pin.serialIn && !st.busy) begin
            nxt.phase = eep_pkg::P_CMD;
            nxt.bitCnt = '0;
            nxt.statusShow = 1'b0;
            nxt.doutEn = 1'b0;
          end
        end
        eep_pkg::P_CMD: begin
          if (shiftRise) begin
            nxt.cmdSr = w;
            nxt.bitCnt = st.bitCnt + 5'h01;
            if (st.bitCnt == eep_pkg::LAST_CMD_BIT) begin
              nxt.unlockPend = 1'b0;
              nxt.phase = eep_pkg::P_DONE;
              nxt.cmdAddr = ea;
              unique case (w[9:8])
                eep_pkg::OP_READ: begin
                  nxt.phase = eep_pkg::P_READ;
                  nxt.dout = 1'b0;
                  nxt.doutEn = 1'b1;
                  nxt.outSeq = !guard;
                  nxt.prefRun = !guard;
                  nxt.prefAddr = ea;
                  nxt.outSr = {st.guardAddr, 8'h00};
                  nxt.outLeft = guard ? eep_pkg::GUARD_BITS : 5'h00;
                end
                eep_pkg::OP_WRITE: begin
                  if (!guard) begin
                    nxt.phase = eep_pkg::P_DATA;
                    nxt.bitCnt = '0;
                    if (st.writeEn && progEn && canWrite) begin
                      nxt.armOp = eep_pkg::WRITE_ONE_CMD;
                    end
                  end else if (st.unlockPend && progEn && !st.guardValid && !st.frozen) begin
                    nxt.armOp = eep_pkg::GUARD_SET_CMD;
                  end
                end
                eep_pkg::OP_CLEAR: begin
                  if (guard && progEn && st.unlockPend && !st.frozen &&
                      w[7:0] == eep_pkg::FIELD_ONES) begin
                    nxt.armOp = eep_pkg::GUARD_CLEAR_CMD;
                  end
                end
                eep_pkg::OP_EXT: begin
                  unique case (w[7:6])
                    eep_pkg::SUB_UNLOCK: begin
                      if (guard) begin
                        if (progEn && st.writeEn) begin
                          nxt.unlockPend = 1'b1;
                        end
                      end else if (progEn) begin
                        nxt.writeEn = 1'b1;
                      end
                    end
                    eep_pkg::SUB_FILL: begin
                      if (!guard) begin
                        nxt.phase = eep_pkg::P_DATA;
                        nxt.bitCnt = '0;
                        if (st.writeEn && progEn && !st.guardValid) begin
                          nxt.armOp = eep_pkg::FILL_ALL_CMD;
                        end
                      end
                    end
                    eep_pkg::SUB_LOCK: begin
                      if (!guard) begin
                        nxt.writeEn = 1'b0;
                      end else if (progEn && st.unlockPend && !st.frozen &&
                                   w[7:0] == eep_pkg::FIELD_ZERO) begin
                        nxt.armOp = eep_pkg::GUARD_FREEZE_CMD;
                      end
                    end
                    default: begin
                    end
                  endcase
                end
              endcase
            end
          end
        end
        eep_pkg::P_DATA: begin
          if (shiftRise) begin
            nxt.dataSr = {st.dataSr[14:0], pin.serialIn};
            nxt.bitCnt = st.bitCnt + 5'h01;
            if (st.bitCnt == eep_pkg::LAST_DATA_BIT) begin
              nxt.phase = eep_pkg::P_DONE;
            end
          end
        end
        eep_pkg::P_READ: begin
          if (shiftRise) begin
            if (st.outLeft != 5'h00) begin
              nxt.dout = st.outSr[15];
              nxt.outSr = {st.outSr[14:0], 1'b0};
              nxt.outLeft = st.outLeft - 5'h01;
            end else if (st.outSeq && popValid) begin
              popReady = 1'b1;
              nxt.dout = popData[15];
              nxt.outSr = {popData[14:0], 1'b0};
              nxt.outLeft = eep_pkg::WORD_REST;
            end else begin
              nxt.dout = 1'b0;
            end
          end
        end
        eep_pkg::P_DONE: begin
          // an extra clock after the last bit cancels the programming
          if (shiftRise) begin
            nxt.armOp = eep_pkg::CMD_NONE;
          end
        end
        default: begin
          nxt.phase = eep_pkg::P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.mem <= '1;
    end else if (ce) begin
      st <= nxt;
    end
  end

  assign serialOut = st.dout;
  assign serialOutEn = st.doutEn;
  assign programBusy = st.busy;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst || !ce);

  sequence armedFall;
    csFall && st.phase == eep_pkg::P_DONE && st.armOp != eep_pkg::CMD_NONE && !st.busy;
  endsequence

  sequence busyStart;
    st.busy && st.statusShow && st.busyCnt == '0;
  endsequence

  sequence readDecode;
    st.phase == eep_pkg::P_CMD && shiftRise && pin.chipSel &&
    st.bitCnt == eep_pkg::LAST_CMD_BIT && w[9:8] == eep_pkg::OP_READ;
  endsequence

  a_program_start: assert property (armedFall |=> busyStart)
    else $error("programming did not start at chip select fall");

  a_status_shown: assert property (
    (pin.chipSel && st.phase == eep_pkg::P_IDLE && st.statusShow && !shiftRise)
    |=> (st.doutEn && st.dout == !st.busy))
    else $error("ready status not shown on serial output");

  a_dummy_zero: assert property (
    readDecode |=> (st.phase == eep_pkg::P_READ && st.doutEn && !st.dout))
    else $error("read did not start with a zero bit");

  a_word_advance: assert property (
    (pin.chipSel && shiftRise && st.phase == eep_pkg::P_READ && st.outSeq &&
     st.outLeft == 5'h00 && popValid) |=> (st.outLeft == eep_pkg::WORD_REST))
    else $error("sequential read did not advance to next word");

  a_addr_masked: assert property (st.prefAddr <= eep_pkg::ADDR_MASK)
    else $error("prefetch address beyond array");

  a_fill_cleared: assert property (
    (st.busy && st.pendOp == eep_pkg::FILL_ALL_CMD) |-> !st.guardValid)
    else $error("fill-all started while guard set");

  a_unlock_wen: assert property ($rose(st.unlockPend) |-> st.writeEn)
    else $error("guard unlock accepted without write unlock");

  a_clear_unlock: assert property (
    $changed(st.armOp) && st.armOp == eep_pkg::GUARD_CLEAR_CMD |-> $past(st.unlockPend))
    else $error("guard clear armed without preceding unlock");

  a_set_guarded: assert property (
    $changed(st.armOp) && st.armOp == eep_pkg::GUARD_SET_CMD
    |-> ($past(st.unlockPend) && !$past(st.guardValid)))
    else $error("guard set armed without clear and unlock");

  a_frozen_guard: assert property (
    st.frozen |=> (st.frozen && $stable(st.guardAddr) && $stable(st.guardValid)))
    else $error("guard changed after freeze");

  a_write_guard: assert property (
    (st.busy && st.pendOp == eep_pkg::WRITE_ONE_CMD && st.guardValid)
    |-> st.pendAddr < st.guardAddr)
    else $error("write started on protected address");

  a_unlock_quiet: assert property ($rose(st.unlockPend) |-> !st.doutEn)
    else $error("serial output driven during guard unlock");

  a_unlock_cancel: assert property (
    (st.unlockPend && st.phase == eep_pkg::P_CMD && shiftRise && pin.chipSel &&
     st.bitCnt == eep_pkg::LAST_CMD_BIT) |=> !st.unlockPend)
    else $error("pending unlock survived a further instruction");
endmodule
`default_nettype wire

// ==== src/eep_pkg.sv ====
`default_nettype none
package eep_pkg;
  localparam int ADDR_W = 8;
  localparam int ARRAY_DEPTH = 128;
  localparam int DATA_W = 16;
  localparam int CMD_BITS = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_MHZ = 25;
  localparam int TWP_MS = 15;
  localparam int WRITE_CYCLES = TWP_MS * 1000 * CLK_MHZ;
  localparam int BUSY_W = 19;
  localparam logic [7:0] ADDR_MASK = 8'(ARRAY_DEPTH - 1);
  localparam logic [7:0] FIELD_ONES = 8'hFF;
  localparam logic [7:0] FIELD_ZERO = 8'h00;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_CLEAR = 2'h3;
  localparam logic [1:0] SUB_LOCK = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;
  localparam logic [4:0] LAST_CMD_BIT = 5'(CMD_BITS - 1);
  localparam logic [4:0] LAST_DATA_BIT = 5'(DATA_W - 1);
  localparam logic [4:0] WORD_REST = 5'(DATA_W - 1);
  localparam logic [4:0] GUARD_BITS = 5'(ADDR_W);

  typedef enum logic [2:0] {
    P_IDLE = 3'h0,
    P_CMD  = 3'h1,
    P_DATA = 3'h2,
    P_READ = 3'h3,
    P_DONE = 3'h4
  } phase_t;

  typedef enum logic [2:0] {
    CMD_NONE         = 3'h0,
    WRITE_ONE_CMD    = 3'h1,
    FILL_ALL_CMD     = 3'h2,
    GUARD_CLEAR_CMD  = 3'h3,
    GUARD_SET_CMD    = 3'h4,
    GUARD_FREEZE_CMD = 3'h5
  } cmd_t;

  typedef struct packed {
    logic chipSel;
    logic shiftClock;
    logic serialIn;
    logic protectAccess;
    logic programEnable;
  } pins_t;

  typedef struct packed {
    phase_t                               phase;
    logic [4:0]                           bitCnt;
    logic [9:0]                           cmdSr;
    logic [7:0]                           cmdAddr;
    logic [15:0]                          dataSr;
    logic [15:0]                          outSr;
    logic [4:0]                           outLeft;
    logic                                 outSeq;
    logic                                 dout;
    logic                                 doutEn;
    logic                                 writeEn;
    logic                                 unlockPend;
    logic                                 guardValid;
    logic [7:0]                           guardAddr;
    logic                                 frozen;
    cmd_t                                 armOp;
    cmd_t                                 pendOp;
    logic [7:0]                           pendAddr;
    logic [15:0]                          pendData;
    logic                                 busy;
    logic [BUSY_W-1:0]                    busyCnt;
    logic                                 statusShow;
    logic                                 prefRun;
    logic [7:0]                           prefAddr;
    logic                                 shiftPrev;
    logic                                 csPrev;
    logic [ARRAY_DEPTH-1:0][DATA_W-1:0]   mem;
  } core_state_t;
endpackage
`default_nettype wire

// ==== src/pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 5
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;

  sync_t st;
  sync_t nxt;

  // first stage feeds only the second
  always_comb begin
    nxt = st;
    nxt.meta = d;
    nxt.stable = st.meta;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (ce) begin
      st <= nxt;
    end
  end

  assign q = st.stable;
endmodule
`default_nettype wire

// ==== src/word_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic      [W-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } fifo_t;

  fifo_t st;
  fifo_t nxt;
  logic  doPush;
  logic  doPop;

  assign inReady = st.cnt != (AW+1)'(DEPTH);
  assign outValid = st.cnt != '0;
  assign outData = st.mem[st.rd];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // depth must be a power of two, pointers wrap by overflow
  always_comb begin
    nxt = st;
    if (flush) begin
      nxt.wr = '0;
      nxt.rd = '0;
      nxt.cnt = '0;
    end else begin
      if (doPush) begin
        nxt.mem[st.wr] = inData;
        nxt.wr = st.wr + 1'b1;
      end
      if (doPop) begin
        nxt.rd = st.rd + 1'b1;
      end
      nxt.cnt = st.cnt + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (ce) begin
      st <= nxt;
    end
  end
endmodule
`default_nettype wire

// ==== dv/eep_master.sv ====
`timescale 1ns/100ps
`default_nettype none
module eep_master (
  input  wire logic core_clk,
  input  wire logic serialOut,
  input  wire logic serialOutEn,
  output logic      chipSelect,
  output logic      shiftClock,
  output logic      serialIn,
  output logic      protectAccessPin,
  output logic      programEnablePin
);
  initial begin
    chipSelect = 1'b0;
    shiftClock = 1'b0;
    serialIn = 1'b0;
    protectAccessPin = 1'b0;
    programEnablePin = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // 5-cycle phases, well above the pin sync latency
  task automatic shiftBit(input logic b, output logic so, inout logic en);
    @(posedge core_clk);
    shiftClock <= 1'b0;
    serialIn   <= b;
    tick(4);
    @(posedge core_clk);
    shiftClock <= 1'b1;
    tick(4);
    @(negedge core_clk);
    // a released line reads as the opposite of its last value
    so = serialOutEn ? serialOut : !serialOut;
    en = en | serialOutEn;
  endtask
  task automatic setCs(input logic v);
    @(posedge core_clk);
    chipSelect <= v;
  endtask
  // clock stands still between frames, data line shows junk once released
  task automatic endFrame();
    @(posedge core_clk);
    chipSelect <= 1'b0;
    shiftClock <= 1'b0;
    serialIn   <= ~serialIn;
    tick(6);
  endtask
  task automatic xfer(input logic [1:0] op, input logic [7:0] adr, input logic pre,
                      input logic progEn, input int nData, input logic [15:0] dat,
                      input int nRd, output logic [31:0] rd, output logic dummy,
                      output logic enSeen);
    logic [10:0] head;
    logic        so;
    int          i;
    head = {1'b1, op, adr};
    rd = '0;
    enSeen = 1'b0;
    @(posedge core_clk);
    chipSelect       <= 1'b1;
    protectAccessPin <= pre;
    programEnablePin <= progEn;
    tick(3);
    for (i = 10; i >= 0; i--) shiftBit(head[i], so, enSeen);
    dummy = so;
    for (i = nData - 1; i >= 0; i--) shiftBit(dat[i], so, enSeen);
    for (i = 0; i < nRd; i++) begin
      shiftBit(1'b0, so, enSeen);
      rd = {rd[30:0], so};
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int WCYC  = 20;
  localparam int LIMIT = 30000;
  logic        core_clk;
  logic        sys_rst;
  logic        ce;
  wire logic   chipSelect;
  wire logic   shiftClock;
  wire logic   serialIn;
  wire logic   protectAccessPin;
  wire logic   programEnablePin;
  wire logic   serialOut;
  wire logic   serialOutEn;
  wire logic   programBusy;
  logic [31:0] rd;
  logic        dummy;
  logic        enSeen;
  int          badCount = 0;
  int          cmpCount = 0;
  int          cycleCnt = 0;

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  protected_serial_eeprom_cmd #(.WRITE_CYCLES(WCYC)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .chipSelect(chipSelect),
    .shiftClock(shiftClock), .serialIn(serialIn), .protectAccessPin(protectAccessPin),
    .programEnablePin(programEnablePin), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .programBusy(programBusy)
  );
  eep_master partner (
    .core_clk(core_clk), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .chipSelect(chipSelect), .shiftClock(shiftClock), .serialIn(serialIn),
    .protectAccessPin(protectAccessPin), .programEnablePin(programEnablePin)
  );

  task automatic finalReport();
    $display("comparisons=%0d mismatches=%0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chkBit(input logic got, input logic exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input logic [1:0] op, input logic [7:0] adr, input logic pre,
                     input logic progEn, input int nData, input logic [15:0] dat, input int nRd);
    partner.xfer(op, adr, pre, progEn, nData, dat, nRd, rd, dummy, enSeen);
  endtask
  task automatic wen();
    run(eep_pkg::OP_EXT, 8'hC0, 1'b0, 1'b1, 0, 16'h0000, 0);
    partner.endFrame();
  endtask
  task automatic unlock();
    run(eep_pkg::OP_EXT, 8'hC0, 1'b1, 1'b1, 0, 16'h0000, 0);
    chkBit(enSeen, 1'b0);
    partner.endFrame();
  endtask
  task automatic guardRead(input logic [7:0] exp);
    run(eep_pkg::OP_READ, 8'h00, 1'b1, 1'b0, 0, 16'h0000, 8);
    partner.endFrame();
    chkBit(dummy, 1'b0);
    chkWord(rd, {24'h000000, exp});
  endtask
  // ends the frame, checks whether a busy cycle started and, if one did, walks the status
  task automatic prog(input logic expBusy);
    int i;
    partner.endFrame();
    @(negedge core_clk);
    chkBit(programBusy, expBusy);
    if (expBusy) begin
      partner.setCs(1'b1);
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      chkBit(serialOutEn, 1'b1);
      chkBit(serialOut, 1'b0);
      for (i = 0; i < 4 * WCYC && serialOut !== 1'b1; i++) @(negedge core_clk);
      chkBit(serialOut, 1'b1);
      chkBit(programBusy, 1'b0);
      partner.endFrame();
    end
  endtask

  task automatic testReset();
    chkBit(serialOutEn, 1'b0);
    chkBit(programBusy, 1'b0);
  endtask
  task automatic testWrite();
    wen();
    run(eep_pkg::OP_WRITE, 8'h85, 1'b0, 1'b1, 16, 16'hA5C3, 0);
    prog(1'b1);
    run(eep_pkg::OP_READ, 8'h05, 1'b0, 1'b0, 0, 16'h0000, 32);
    partner.endFrame();
    chkBit(dummy, 1'b0);
    chkWord(rd, 32'hA5C3FFFF);
    run(eep_pkg::OP_READ, 8'h85, 1'b0, 1'b0, 0, 16'h0000, 16);
    partner.endFrame();
    chkWord(rd, 32'h0000A5C3);
  endtask
  task automatic testGuardOrder();
    run(eep_pkg::OP_EXT, 8'h00, 1'b0, 1'b0, 0, 16'h0000, 0);
    partner.endFrame();
    unlock();
    run(eep_pkg::OP_CLEAR, 8'hFF, 1'b1, 1'b1, 0, 16'h0000, 0);
    prog(1'b0);
    wen();
    unlock();
    run(eep_pkg::OP_READ, 8'h00, 1'b0, 1'b0, 0, 16'h0000, 0);
    partner.endFrame();
    run(eep_pkg::OP_CLEAR, 8'hFF, 1'b1, 1'b1, 0, 16'h0000, 0);
    prog(1'b0);
    run(eep_pkg::OP_WRITE, 8'h10, 1'b1, 1'b1, 0, 16'h0000, 0);
    prog(1'b0);
    unlock();
    run(eep_pkg::OP_WRITE, 8'h10, 1'b1, 1'b1, 0, 16'h0000, 0);
    prog(1'b1);
    guardRead(8'h10);
    run(eep_pkg::OP_WRITE, 8'h20, 1'b0, 1'b1, 16, 16'h1234, 0);
    prog(1'b0);
    run(eep_pkg::OP_WRITE, 8'h0F, 1'b0, 1'b1, 16, 16'h1234, 0);
    prog(1'b1);
    unlock();
    run(eep_pkg::OP_WRITE, 8'h08, 1'b1, 1'b1, 0, 16'h0000, 0);
    prog(1'b0);
    run(eep_pkg::OP_EXT, 8'h40, 1'b0, 1'b1, 16, 16'h5A5A, 0);
    prog(1'b0);
  endtask
  task automatic testFill();
    unlock();
    run(eep_pkg::OP_CLEAR, 8'hFF, 1'b1, 1'b1, 0, 16'h0000, 0);
    prog(1'b1);
    run(eep_pkg::OP_EXT, 8'h40, 1'b0, 1'b1, 16, 16'h5A5A, 0);
    prog(1'b1);
    run(eep_pkg::OP_READ, 8'h30, 1'b0, 1'b0, 0, 16'h0000, 16);
    partner.endFrame();
    chkWord(rd, 32'h00005A5A);
  endtask
  task automatic testFreeze();
    unlock();
    run(eep_pkg::OP_WRITE, 8'h40, 1'b1, 1'b1, 0, 16'h0000, 0);
    prog(1'b1);
    unlock();
    run(eep_pkg::OP_EXT, 8'h00, 1'b1, 1'b1, 0, 16'h0000, 0);
    prog(1'b1);
    unlock();
    run(eep_pkg::OP_CLEAR, 8'hFF, 1'b1, 1'b1, 0, 16'h0000, 0);
    prog(1'b0);
    run(eep_pkg::OP_WRITE, 8'h50, 1'b0, 1'b1, 16, 16'h0F0F, 0);
    prog(1'b0);
    guardRead(8'h40);
  endtask

  always @(posedge core_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == LIMIT) begin
      badCount++;
      finalReport();
    end
  end

  initial begin
    sys_rst <= 1'b1;
    ce <= 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    testReset();
    testWrite();
    testGuardOrder();
    testFill();
    testFreeze();
    finalReport();
  end
endmodule
`default_nettype wire
